// ---- common/dcpmc_pkg.sv ----
// ==========================================================
// Power and clock mode control constants
package dcpmc_pkg;
	// ==========================================================
	// Register map (byte addresses, one word each)
	localparam logic [7:0] ADR_CTRL = 8'h00; // Mode control
	localparam logic [7:0] ADR_STAT = 8'h04; // Status; writing one to S_ILL clears the illegal flag
	localparam logic [7:0] ADR_CMD = 8'h08; // Power save command
	// ==========================================================
	// Control register layout
	localparam logic [7:0] CTRL_RST = 8'h40; // Fast oscillator only
	localparam logic [7:0] CTRL_WMASK = 8'hF7; // Reserved bit held 0
	localparam int B_SLOW_ON = 7;
	localparam int B_FAST_ON = 6;
	localparam int B_IT_SLOW = 5;
	localparam int B_CORE_SLOW = 4;
	localparam int B_WIN_HI = 2;
	// ==========================================================
	// Legal upper nibbles: slow, fast, idle select, core select
	localparam logic [3:0] NIB_HS = 4'h4;
	localparam logic [3:0] NIB_HS_DC = 4'hC;
	localparam logic [3:0] NIB_DC = 4'hE;
	localparam logic [3:0] NIB_DC_LS = 4'hF;
	localparam logic [3:0] NIB_LS = 4'hB;
	// ==========================================================
	// Command register codes
	localparam logic [1:0] CMD_HALT = 2'h1;
	localparam logic [1:0] CMD_IDLE = 2'h2;
	// Status register layout
	localparam int S_MODE_LO = 0;
	localparam int S_PWR_LO = 2;
	localparam int S_ILL = 4;
	localparam int S_HALT_OK = 5;
	// ==========================================================
	// Idle timer
	localparam int TMR_W = 17; // Covers the 64k tap
	localparam int TAP_BASE = 12; // 4,096-cycle tap
	localparam logic [2:0] WIN_MAX = 3'h4; // Fifth window
	// ==========================================================
	// Clock modes and power states
	typedef enum logic [1:0] {
		MODE_HS = 2'b00,
		MODE_DUAL = 2'b01,
		MODE_LS = 2'b10
	} dcpmc_mode_t;
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_IDLE = 2'b01,
		PWR_HALT = 2'b10
	} dcpmc_pwr_t;
endpackage : dcpmc_pkg

// ---- design/dcpmc_top.sv ----
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/10ps
module dcpmc_top #(
	parameter int IDLE_TAP_LSB = dcpmc_pkg::TAP_BASE // Lower to shorten idle windows
) (
	input wire logic CLK_IN, // 10 MHz
	input wire logic SRST_IN, // Synchronous, active high
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	input wire logic HALT_OPTION_IN, // Non-volatile option, pin
	input wire logic WAKE_IN, // Wake-up request, pin
	input wire logic SLOW_TICK_IN, // Slow oscillator clock, pin
	output logic SLOW_OSC_EN_OUT,
	output logic FAST_OSC_EN_OUT,
	output logic IDLE_TIMER_SLOW_OUT,
	output logic CORE_SLOW_OUT,
	output logic CORE_CLK_EN_OUT,
	output logic FREEZE_OUT,
	output logic IDLE_TIMER_EVT_OUT,
	output logic SELF_RESET_OUT,
	output logic [1:0] MODE_OUT,
	output logic [1:0] PWR_STATE_OUT
);
	// ==========================================================
	// Pin synchronisers
	logic halt_opt_s1_ff; // First stage, read only by second
	logic halt_opt_ff;
	logic wake_s1_ff;
	logic wake_ff;
	logic slow_s1_ff;
	logic slow_ff;
	logic slow_d_ff; // Previous slow level for edge detect

	// Two flops before any logic reads a pin
	always_ff @(posedge CLK_IN) begin
		halt_opt_s1_ff <= HALT_OPTION_IN;
		halt_opt_ff <= halt_opt_s1_ff;
		wake_s1_ff <= WAKE_IN;
		wake_ff <= wake_s1_ff;
		slow_s1_ff <= SLOW_TICK_IN;
		slow_ff <= slow_s1_ff;
		slow_d_ff <= slow_ff;
	end

	// ==========================================================
	// Wishbone classic slave
	logic ack_ff; // Registered acknowledge
	logic [31:0] rdat_ff; // Registered read data
	logic [7:0] ctrl_ff; // Mode control register
	dcpmc_pkg::dcpmc_pwr_t pwr_ff; // Power save state
	logic ill_ff; // Sticky: last reset was an illegal write
	logic [dcpmc_pkg::TMR_W-1:0] it_cnt_ff; // Idle timer

	wire wb_req = WB_CYC_IN & WB_STB_IN;
	// One wait state: ack rises the cycle after the request
	wire wb_commit = wb_req & ack_ff;
	wire sel_ctrl = (WB_ADR_IN == dcpmc_pkg::ADR_CTRL);
	wire sel_stat = (WB_ADR_IN == dcpmc_pkg::ADR_STAT);
	wire sel_cmd = (WB_ADR_IN == dcpmc_pkg::ADR_CMD);
	wire wr_lane0 = wb_commit & WB_WE_IN & WB_SEL_IN[0];
	wire ctrl_wr = wr_lane0 & sel_ctrl;
	wire stat_wr = wr_lane0 & sel_stat;
	wire cmd_wr = wr_lane0 & sel_cmd;
	wire [7:0] wr_byte = WB_DAT_IN[7:0] & dcpmc_pkg::CTRL_WMASK;

	// ==========================================================
	// Legality of the written upper nibble
	wire [3:0] wr_nib = wr_byte[7:4];
	// Checked on the written value, before it reaches the selects
	wire nib_legal = (wr_nib == dcpmc_pkg::NIB_HS) |
		(wr_nib == dcpmc_pkg::NIB_HS_DC) |
		(wr_nib == dcpmc_pkg::NIB_DC) |
		(wr_nib == dcpmc_pkg::NIB_DC_LS) |
		(wr_nib == dcpmc_pkg::NIB_LS);
	wire ill_wr = ctrl_wr & ~nib_legal;
	// Internal reset: pin reset or illegal write
	wire any_rst = SRST_IN | ill_wr;

	// ==========================================================
	// Clock mode decode
	wire it_slow_bit = ctrl_ff[dcpmc_pkg::B_IT_SLOW];
	wire core_slow_bit = ctrl_ff[dcpmc_pkg::B_CORE_SLOW];
	// Invalid 0/1 pair is in no legal nibble and is never stored; it would be forced slow
	wire force_slow = ~it_slow_bit & core_slow_bit;
	wire it_slow = it_slow_bit | force_slow;
	wire core_slow = core_slow_bit;
	dcpmc_pkg::dcpmc_mode_t mode;
	// Mode from the two select bits
	assign mode = (it_slow & core_slow) ? dcpmc_pkg::MODE_LS :
		it_slow ? dcpmc_pkg::MODE_DUAL :
		dcpmc_pkg::MODE_HS;

	// ==========================================================
	// Power save state
	wire is_halt = (pwr_ff == dcpmc_pkg::PWR_HALT);
	wire is_idle = (pwr_ff == dcpmc_pkg::PWR_IDLE);
	wire is_run = (pwr_ff == dcpmc_pkg::PWR_RUN);
	wire halt_req = cmd_wr & (WB_DAT_IN[1:0] == dcpmc_pkg::CMD_HALT) & halt_opt_ff;
	wire idle_req = cmd_wr & (WB_DAT_IN[1:0] == dcpmc_pkg::CMD_IDLE);

	// ==========================================================
	// Idle timer window tap
	wire [2:0] win_sel = ctrl_ff[dcpmc_pkg::B_WIN_HI:0];
	// Codes above the fifth window fall back to the longest tap
	wire [2:0] win_eff = (win_sel > dcpmc_pkg::WIN_MAX) ? dcpmc_pkg::WIN_MAX : win_sel;
	wire [4:0] tap_idx = 5'(IDLE_TAP_LSB) + {2'h0, win_eff};
	wire tap_bit = it_cnt_ff[tap_idx];
	logic tap_d_ff; // Tap value one cycle ago
	logic evt_ff; // Registered window event
	// Timer stops in halt; runs in run and idle
	wire slow_edge = slow_ff & ~slow_d_ff;
	wire it_tick = ~is_halt & (it_slow ? slow_edge : ctrl_ff[dcpmc_pkg::B_FAST_ON]);
	wire tap_evt = tap_bit ^ tap_d_ff;

	// Next power state
	dcpmc_pkg::dcpmc_pwr_t nxt_pwr;
	always_comb begin
		nxt_pwr = pwr_ff;
		case (pwr_ff)
			// Requests only taken while running
			dcpmc_pkg::PWR_RUN: begin
				if (halt_req) begin
					nxt_pwr = dcpmc_pkg::PWR_HALT;
				end else if (idle_req) begin
					nxt_pwr = dcpmc_pkg::PWR_IDLE;
				end
			end
			// Idle ends on window event or wake-up
			dcpmc_pkg::PWR_IDLE: begin
				if (tap_evt | wake_ff) begin
					nxt_pwr = dcpmc_pkg::PWR_RUN;
				end
			end
			// Halt ends only on wake-up or reset
			dcpmc_pkg::PWR_HALT: begin
				if (wake_ff) begin
					nxt_pwr = dcpmc_pkg::PWR_RUN;
				end
			end
			default: begin
				nxt_pwr = dcpmc_pkg::PWR_RUN;
			end
		endcase
	end

	// ==========================================================
	// Register processes
	// Acknowledge and read data
	wire [31:0] stat_word = {26'h0, halt_opt_ff, ill_ff, pwr_ff, mode};
	wire [31:0] rd_mux = sel_ctrl ? {24'h0, ctrl_ff} :
		sel_stat ? stat_word :
		32'h0; // Unmapped and command read as zero
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
		end else begin
			ack_ff <= wb_req & ~ack_ff;
			if (wb_req & ~ack_ff) begin
				rdat_ff <= rd_mux;
			end
		end
	end

	// Control register; any reset restores fast-only state
	always_ff @(posedge CLK_IN) begin
		if (any_rst) begin
			ctrl_ff <= dcpmc_pkg::CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_ff <= wr_byte;
		end
	end

	// Power state
	always_ff @(posedge CLK_IN) begin
		if (any_rst) begin
			pwr_ff <= dcpmc_pkg::PWR_RUN;
		end else begin
			pwr_ff <= nxt_pwr;
		end
	end

	// Sticky illegal flag, set wins over write-one clear
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			ill_ff <= 1'b0;
		end else if (ill_wr) begin
			ill_ff <= 1'b1;
		end else if (stat_wr & WB_DAT_IN[dcpmc_pkg::S_ILL]) begin
			ill_ff <= 1'b0;
		end
	end

	// Idle timer cleared by the pin reset only; a self reset leaves it counting
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			it_cnt_ff <= '0;
			tap_d_ff <= 1'b0;
			evt_ff <= 1'b0;
		end else begin
			if (it_tick) begin
				it_cnt_ff <= it_cnt_ff + 1'b1;
			end
			tap_d_ff <= tap_bit;
			evt_ff <= tap_evt;
		end
	end

	// Self reset pulse
	logic srst_pulse_ff;
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			srst_pulse_ff <= 1'b0;
		end else begin
			srst_pulse_ff <= ill_wr;
		end
	end

	// ==========================================================
	// Outputs; halt stops both oscillators
	assign SLOW_OSC_EN_OUT = ctrl_ff[dcpmc_pkg::B_SLOW_ON] & ~is_halt;
	assign FAST_OSC_EN_OUT = ctrl_ff[dcpmc_pkg::B_FAST_ON] & ~is_halt;
	assign IDLE_TIMER_SLOW_OUT = it_slow;
	assign CORE_SLOW_OUT = core_slow;
	assign CORE_CLK_EN_OUT = is_run;
	assign FREEZE_OUT = ~is_run;
	assign IDLE_TIMER_EVT_OUT = evt_ff;
	assign SELF_RESET_OUT = srst_pulse_ff;
	assign MODE_OUT = mode;
	assign PWR_STATE_OUT = pwr_ff;
	assign WB_ACK_OUT = ack_ff;
	assign WB_DAT_OUT = rdat_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);

	reset_value_a: assert property ($rose(SELF_RESET_OUT) |-> ctrl_ff == dcpmc_pkg::CTRL_RST)
		else $error("control not restored to reset value");
	slow_osc_a: assert property (!is_halt |-> SLOW_OSC_EN_OUT == ctrl_ff[dcpmc_pkg::B_SLOW_ON])
		else $error("slow oscillator enable mismatch");
	fast_osc_a: assert property (is_halt |-> !FAST_OSC_EN_OUT && !SLOW_OSC_EN_OUT)
		else $error("oscillator running in halt");
	mode_decode_a: assert property (MODE_OUT == dcpmc_pkg::MODE_DUAL |-> IDLE_TIMER_SLOW_OUT && !CORE_SLOW_OUT)
		else $error("dual mode decode wrong");
	legal_store_a: assert property (ctrl_wr && nib_legal |=> ctrl_ff == $past(wr_byte))
		else $error("legal write not stored");
	illegal_reset_a: assert property (ill_wr |=> SELF_RESET_OUT && pwr_ff == dcpmc_pkg::PWR_RUN && ill_ff)
		else $error("illegal write did not reset");
	halt_gate_a: assert property (is_run && cmd_wr && !halt_opt_ff && !idle_req |=> is_run)
		else $error("halt taken while disabled");
	idle_clock_a: assert property (is_idle |-> !CORE_CLK_EN_OUT && FREEZE_OUT)
		else $error("core clock running in idle");
	timer_freeze_a: assert property (is_halt ##1 is_halt |-> $stable(it_cnt_ff))
		else $error("idle timer moved in halt");
	window_exit_a: assert property (is_idle && tap_evt && !ctrl_wr |=> is_run && IDLE_TIMER_EVT_OUT)
		else $error("idle not left on window event");
endmodule : dcpmc_top

// ---- testbench/dcpmc_top_bench.sv ----
`timescale 1ns/10ps
module dcpmc_top_bench;
	// ==========================================================
	// Stimulus, observation and model state
	logic clk_in, srst_in, cyc, stb, we, hopt, wake, stick;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd;
	logic ack, sosc, fosc, itslow, cslow, cken, frz, evt, selfrst;
	logic [1:0] mode, pwr;
	int fail_count, checks, mdl, sticky, n, i;
	logic [3:0] chain [9] = '{4'h4, 4'hC, 4'hE, 4'hF, 4'hB, 4'hF, 4'hE, 4'hC, 4'h4}; // Legal walk, up and back
	// Every nibble once: legal ones in chain order, then illegal ones, each falling back to fast only
	logic [3:0] sweep [16] = '{4'h4, 4'hC, 4'hE, 4'hF, 4'hB, 4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
		4'hA, 4'hD};
	dcpmc_top #(.IDLE_TAP_LSB(2)) dut (.CLK_IN(clk_in), .SRST_IN(srst_in), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
		.HALT_OPTION_IN(hopt), .WAKE_IN(wake), .SLOW_TICK_IN(stick), .SLOW_OSC_EN_OUT(sosc),
		.FAST_OSC_EN_OUT(fosc), .IDLE_TIMER_SLOW_OUT(itslow), .CORE_SLOW_OUT(cslow), .CORE_CLK_EN_OUT(cken),
		.FREEZE_OUT(frz), .IDLE_TIMER_EVT_OUT(evt), .SELF_RESET_OUT(selfrst), .MODE_OUT(mode), .PWR_STATE_OUT(pwr));
	// ==========================================================
	// Clock, slow square wave (rising every 4 cycles) and watchdog
	initial begin
		clk_in = 0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		stick = 0;
		forever begin
			repeat (2) @(posedge clk_in);
			stick <= ~stick;
		end
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		close_out();
	end
	// ==========================================================
	// Shared tasks
	task close_out();
		if (fail_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Classic cycle; holds the request until ack is sampled high, the watchdog ends a hang
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_in);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_in);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask : wb
	function logic [1:0] emode(input logic [7:0] c);
		if (c[4]) return 2'b10; // Core on slow: slow mode, also for the invalid pair
		return c[5] ? 2'b01 : 2'b00;
	endfunction : emode
	// Write control, then compare pulse, readback, pins and status with the model
	task setc(input logic [7:0] v);
		int p;
		logic ill;
		ill = !(v[7:4] inside {4'h4, 4'hC, 4'hE, 4'hF, 4'hB});
		wb(1, dcpmc_pkg::ADR_CTRL, {24'h0, v}, 4'hF);
		p = 0;
		repeat (3) begin
			@(posedge clk_in);
			p += (selfrst === 1'b1);
		end
		chk(p, ill);
		mdl = ill ? 32'h40 : v & 8'hF7;
		if (ill) sticky = 1;
		wb(0, dcpmc_pkg::ADR_CTRL, 0, 4'hF);
		chk(rd, mdl);
		chk({sosc, fosc, itslow, cslow}, mdl[7:4]);
		chk(mode, emode(mdl));
		wb(0, dcpmc_pkg::ADR_STAT, 0, 4'hF);
		chk(rd, {26'h0, hopt, sticky[0], 2'b00, emode(mdl)});
		wb(1, dcpmc_pkg::ADR_STAT, 32'h10, 4'hF);
		sticky = 0;
	endtask : setc
	// Cycles between two idle timer events
	task gap(output int g);
		int k;
		k = 0;
		while (evt !== 1'b1 && k < 5000) begin
			@(posedge clk_in);
			k++;
		end
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (evt !== 1'b1 && k < 5000);
		g = k;
	endtask : gap
	// ==========================================================
	// Main sequence
	initial begin
		srst_in = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0; hopt = 0; wake = 0;
		fail_count = 0; checks = 0; sticky = 0;
		void'($urandom(32'h685d97f0));
		repeat (3) @(posedge clk_in);
		srst_in <= 0;
		wb(0, dcpmc_pkg::ADR_CTRL, 0, 4'hF);
		chk(rd, 32'h40);
		chk({sosc, fosc, mode}, 4'h4);
		// Walk the legal chain with random window bits, reserved bit kept 0
		for (i = 0; i < 9; i++) setc({chain[i], 1'b0, 3'($urandom)});
		// Every upper nibble once; illegal ones must fall back
		for (i = 0; i < 16; i++) setc({sweep[i], 4'h1});
		setc(8'h40);
		wb(0, 8'h0C, 0, 4'hF);
		chk(rd, 0);
		wb(1, dcpmc_pkg::ADR_CTRL, 32'hC0, 4'hE);
		wb(0, dcpmc_pkg::ADR_CTRL, 0, 4'hF);
		chk(rd, 32'h40);
		// Window spacing on the fast clock; codes above four act as four
		for (i = 0; i < 6; i++) begin
			setc({5'h08, i[2:0]});
			gap(n);
			gap(n);
			chk(n, 1 << (2 + (i > 4 ? 4 : i)));
		end
		// Dual mode: idle timer follows the slow ticks
		setc(8'hC0);
		setc(8'hE0);
		gap(n);
		gap(n);
		chk(n, 16);
		setc(8'hC0);
		setc(8'h40);
		// Halt refused while the option is low
		wb(1, dcpmc_pkg::ADR_CMD, 32'h1, 4'hF);
		repeat (3) @(posedge clk_in);
		chk(pwr, 2'b00);
		hopt <= 1;
		repeat (5) @(posedge clk_in);
		wb(1, dcpmc_pkg::ADR_CMD, 32'h1, 4'hF);
		repeat (20) @(posedge clk_in);
		chk({pwr, frz, cken, fosc}, 5'b10100);
		wb(0, dcpmc_pkg::ADR_CTRL, 0, 4'hF);
		chk(rd, mdl);
		wake <= 1;
		repeat (5) @(posedge clk_in);
		chk({pwr, cken, fosc}, 4'b0011);
		wake <= 0;
		repeat (5) @(posedge clk_in);
		// Idle keeps the oscillator and ends on the window tap
		setc(8'h44);
		wb(1, dcpmc_pkg::ADR_CMD, 32'h2, 4'hF);
		@(posedge clk_in);
		chk({pwr, frz, fosc}, 4'b0111);
		n = 0;
		while (pwr !== 2'b00 && n < 100) begin
			@(posedge clk_in);
			n++;
		end
		chk({pwr, cken}, 3'b001);
		close_out();
	end
endmodule : dcpmc_top_bench
